// >>> common/pdr_defs.vh
// Constants for the port direction register block.
// Assumes inclusion by bare name from the design files.
`ifndef PDR_DEFS_VH
`define PDR_DEFS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is index shifted left by PDR_ADDR_LSB)
// ----------------------------------------------------------------------
// Printed offset FF21H is not a multiple of four, so FF20H and FF21H are
// register indices and the byte address is four times the index.
`define PDR_PORT0_DIR_INDEX  16'hFF20
`define PDR_PORT1_DIR_INDEX  16'hFF21
`define PDR_BIT_OP_INDEX     16'hFF28
`define PDR_ADDR_LSB         2
`define PDR_INDEX_W          16

// ----------------------------------------------------------------------
// Reset values and fixed bits
// ----------------------------------------------------------------------
`define PDR_DIR_RESET        8'hFF
`define PDR_PORT0_FIXED      8'hFC
`define PDR_PORT0_PINS       2
`define PDR_PORT1_PINS       8

// ----------------------------------------------------------------------
// Single-bit operation word fields
// ----------------------------------------------------------------------
`define PDR_OP_BIT_LSB       0
`define PDR_OP_BIT_MSB       2
`define PDR_OP_VALUE_BIT     3
`define PDR_OP_REG_BIT       4

// ----------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------
`define PDR_RESP_OKAY        2'h0
`define PDR_RESP_SLVERR      2'h2

`endif

// >>> logic/pdr_dir_reg.v
// One eight-bit port direction register with byte and single-bit writes.
// Assumes the caller decodes the address and raises one write at a time.
`timescale 1ns/1ps
`default_nettype none
`include "pdr_defs.vh"

module pdr_dir_reg #(
  parameter [7:0] FIXED_ONES = 8'h00
) (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       byte_we,
  input  wire [7:0] byte_data,
  input  wire       bit_we,
  input  wire [2:0] bit_sel,
  input  wire       bit_value,
  output reg  [7:0] dir
);

  always @(posedge aclk) begin
    if (!aresetn) begin
      dir <= `PDR_DIR_RESET;
    end else if (byte_we) begin
      dir <= byte_data | FIXED_ONES;
    end else if (bit_we) begin
      dir[bit_sel] <= bit_value | FIXED_ONES[bit_sel];
    end
  end

endmodule // pdr_dir_reg
`default_nettype wire

// >>> logic/pdr_port_direction.v
// Port direction registers for the two-pin and eight-pin ports, on AXI4-Lite.
// Assumes a single clock, synchronous active-low reset, one access at a time.
//
// Behaviour
// - Each writable direction bit independently sets its own pin to input or output.
// - Byte writes and single-bit set or clear; bit writes touch one bit.
// - Reset loads every direction register with FFH.
// - Port 0 register at FF20H uses bits 1:0, bits 7:2 read one.
// - After reset every pin of both ports is an input.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "pdr_defs.vh"

module pdr_port_direction (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [17:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [17:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [1:0]  port0_oe_n,
  output reg  [7:0]  port1_oe_n
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function [1:0] pdr_decode;
    input [17:0] addr;
    reg   [15:0] idx;
    begin
      idx = addr[17:`PDR_ADDR_LSB];
      if (idx == `PDR_PORT0_DIR_INDEX) begin
        pdr_decode = 2'h1;
      end else if (idx == `PDR_PORT1_DIR_INDEX) begin
        pdr_decode = 2'h2;
      end else if (idx == `PDR_BIT_OP_INDEX) begin
        pdr_decode = 2'h3;
      end else begin
        pdr_decode = 2'h0;
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // Response and read data selection
  // ----------------------------------------------------------------------
  // Unmapped addresses answer with an error, so a stray pointer in software
  // shows up at once instead of silently doing nothing.
  function [1:0] pdr_resp;
    input [1:0] sel;
    begin
      if (sel == 2'h0) begin
        pdr_resp = `PDR_RESP_SLVERR;
      end else begin
        pdr_resp = `PDR_RESP_OKAY;
      end
    end
  endfunction

  // Only the low byte carries a register; the upper lanes always read zero.
  // The bit-operation word is write-only and reads as zero like a hole.
  function [31:0] pdr_read_word;
    input [1:0] sel;
    input [7:0] p0;
    input [7:0] p1;
    begin
      case (sel)
        2'h1:    pdr_read_word = {24'h000000, p0};
        2'h2:    pdr_read_word = {24'h000000, p1};
        default: pdr_read_word = 32'h00000000;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------------
  // Address and data are latched independently so either may come first.
  // Ready is offered as a one-cycle pulse and withheld while a response is
  // pending, so a second request can never overtake an uncollected answer.
  // A bit operation names its port in bit 4, so one word reaches only one port.
  reg        aw_held;
  reg [17:0] aw_addr;
  reg        w_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;

  wire       do_write  = aw_held && w_held && !s_axi_bvalid;
  wire [1:0] wsel      = pdr_decode(aw_addr);
  wire       lane0     = w_strb[0];
  wire       p0_byte   = do_write && (wsel == 2'h1) && lane0;
  wire       p1_byte   = do_write && (wsel == 2'h2) && lane0;
  wire       op_we     = do_write && (wsel == 2'h3) && lane0;
  wire       p0_bit    = op_we && !w_data[`PDR_OP_REG_BIT];
  wire       p1_bit    = op_we && w_data[`PDR_OP_REG_BIT];
  wire [2:0] op_sel    = w_data[`PDR_OP_BIT_MSB:`PDR_OP_BIT_LSB];
  wire       op_val    = w_data[`PDR_OP_VALUE_BIT];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= 18'h00000;
      w_held        <= 1'b0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PDR_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= pdr_resp(wsel);
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Direction registers
  // ----------------------------------------------------------------------
  wire [7:0] port0_dir;
  wire [7:0] port1_dir;

  pdr_dir_reg #(
    .FIXED_ONES (`PDR_PORT0_FIXED)
  ) u_port0 (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .byte_we   (p0_byte),
    .byte_data (w_data[7:0]),
    .bit_we    (p0_bit),
    .bit_sel   (op_sel),
    .bit_value (op_val),
    .dir       (port0_dir)
  );

  pdr_dir_reg #(
    .FIXED_ONES (8'h00)
  ) u_port1 (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .byte_we   (p1_byte),
    .byte_data (w_data[7:0]),
    .bit_we    (p1_bit),
    .bit_sel   (op_sel),
    .bit_value (op_val),
    .dir       (port1_dir)
  );

  // ----------------------------------------------------------------------
  // Pin enables
  // ----------------------------------------------------------------------
  // Output enables are registered, so a pin turns one cycle after its bit.
  // Port 0 drives only two pins; its fixed upper bits have no pin behind them.
  always @(posedge aclk) begin
    if (!aresetn) begin
      port0_oe_n <= 2'h3;
      port1_oe_n <= `PDR_DIR_RESET;
    end else begin
      port0_oe_n <= port0_dir[`PDR_PORT0_PINS-1:0];
      port1_oe_n <= port1_dir;
    end
  end

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  wire [1:0] rsel = pdr_decode(s_axi_araddr);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PDR_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= pdr_resp(rsel);
        s_axi_rdata   <= pdr_read_word(rsel, port0_dir, port1_dir);
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // pdr_port_direction
`default_nettype wire

// >>> testbench/pdr_port_direction_chk.sv
// Assertions on the direction block's read path and pin enables.
// Assumes one clock and a bind to the top module.
`timescale 1ns/1ps
`default_nettype none
module pdr_port_direction_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [17:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  port0_oe_n,
  input wire logic [7:0]  port1_oe_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
  AST_RST: assert property ($rose(aresetn) |-> port0_oe_n == 2'h3 && port1_oe_n == 8'hFF)
    else $error("pin enables not off after reset");
  AST_P0: assert property (s_ar ##0 s_axi_araddr == 18'h3FC80 |=> s_axi_rdata == {24'h0, 6'h3F, port0_oe_n})
    else $error("port 0 read mismatch");
  AST_P1: assert property (s_ar ##0 s_axi_araddr == 18'h3FC84 |=> s_axi_rdata == {24'h0, port1_oe_n})
    else $error("port 1 read mismatch");
  AST_RLAT: assert property (s_ar |=> s_axi_rvalid)
    else $error("read answer late");
  AST_UNM: assert property (s_ar ##0 s_axi_araddr == 18'h3FC88 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read accepted");
  AST_OE: assert property (!$stable({port0_oe_n, port1_oe_n}) |-> $past(s_axi_bvalid && s_axi_bresp == 2'h0))
    else $error("pin enable moved without write");
endmodule // pdr_port_direction_chk
bind pdr_port_direction pdr_port_direction_chk i_chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_bresp, .s_axi_bvalid, .port0_oe_n, .port1_oe_n);
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the direction block over AXI4-Lite.
// Assumes the checker binds itself to the top module.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, port0_oe_n, rsp;
  logic [31:0] s_axi_rdata, rd_v;
  logic [7:0]  port1_oe_n;
  int          n_mismatch = 0, n_tests = 0;
  always #5 aclk = ~aclk;
  pdr_port_direction i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port0_oe_n,
    .port1_oe_n);
  // ---
  // Bus tasks
  // ---
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // The extra edge lets the pin enables settle before callers look at them.
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
  endtask
  task automatic rd(input logic [17:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd_v = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
  endtask
  // ---
  // Scenarios
  // ---
  task automatic t_reset;
    rd(18'h3FC80);
    chk("port0", 32'hFF, rd_v);
    rd(18'h3FC84);
    chk("port1", 32'hFF, rd_v);
    chk("port1 rresp", 32'h0, rsp);
    chk("oe", 32'h3FF, {port0_oe_n, port1_oe_n});
  endtask
  task automatic t_byte;
    wr(18'h3FC84, 32'h5A);
    chk("port1 bresp", 32'h0, rsp);
    rd(18'h3FC84);
    chk("port1", 32'h5A, rd_v);
    chk("oe1", 32'h5A, port1_oe_n);
    wr(18'h3FC80, 32'h1);
    rd(18'h3FC80);
    chk("port0", 32'hFD, rd_v);
    chk("oe0", 32'h1, port0_oe_n);
  endtask
  task automatic t_bit;
    logic [7:0] e;
    e = 8'h5A;
    for (int i = 0; i < 8; i++) begin
      e[i] = ~e[i];
      wr(18'h3FCA0, {27'h0, 1'b1, e[i], i[2:0]});
      rd(18'h3FC84);
      chk("port1 bit", {24'h0, e}, rd_v);
    end
    wr(18'h3FCA0, 32'h5);
    wr(18'h3FCA0, 32'h9);
    rd(18'h3FC80);
    chk("port0 bit", 32'hFF, rd_v);
    chk("oe0", 32'h3, port0_oe_n);
    rd(18'h3FCA0);
    chk("bit op read", 32'h0, rd_v);
  endtask
  task automatic t_unm;
    wr(18'h3FC88, 32'h0);
    chk("unmapped bresp", 32'h2, rsp);
    rd(18'h3FC88);
    chk("unmapped rresp", 32'h2, rsp);
    s_axi_wstrb <= 4'h0;
    wr(18'h3FC84, 32'h0);
    s_axi_wstrb <= 4'hF;
    chk("masked bresp", 32'h0, rsp);
    rd(18'h3FC84);
    chk("port1 kept", 32'hA5, rd_v);
  endtask
  // Software that hands a pin to a peripheral output clears its direction bit.
  task automatic t_alt;
    wr(18'h3FCA0, 32'h17);
    wr(18'h3FCA0, 32'h0);
    rd(18'h3FC84);
    chk("port1 alt", 32'h25, rd_v);
    rd(18'h3FC80);
    chk("port0 alt", 32'hFE, rd_v);
    chk("oe alt", 32'h225, {port0_oe_n, port1_oe_n});
  endtask
  task automatic t_rerst;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("oe rst", 32'h3FF, {port0_oe_n, port1_oe_n});
    rd(18'h3FC80);
    chk("port0 rst", 32'hFF, rd_v);
    rd(18'h3FC84);
    chk("port1 rst", 32'hFF, rd_v);
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_byte;
    t_bit;
    t_unm;
    t_alt;
    t_rerst;
    close_out;
  end
  initial begin
    #50000;
    n_mismatch++;
    close_out;
  end
endmodule // tb_top
`default_nettype wire
